// file: logic/rscl_link_end.sv
// Link controller end: AXI4-Lite command registers driving the shared lines
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rscl_link_end (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    rscl_if.link             lnk
);
    typedef enum logic [4:0] {
        L_IDLE = 5'h01,
        L_CMD  = 5'h02,
        L_WDAT = 5'h04,
        L_TURN = 5'h08,
        L_RDAT = 5'h10
    } rscl_lstate_e;

    rscl_lstate_e st;
    logic [1:0]   cnt;
    logic [7:0]   shreg;
    logic [7:0]   rd_byte;
    logic [12:0]  cmd;
    logic         go;
    logic         aw_got;
    logic         w_got;
    logic [3:0]   aw_addr;
    logic [31:0]  w_data;
    logic         sysclk_seen;

    wire          aw_hs    = s_axi_awvalid & s_axi_awready;
    wire          w_hs     = s_axi_wvalid & s_axi_wready;
    wire          aw_have  = aw_got | aw_hs;
    wire          w_have   = w_got | w_hs;
    wire          wr_do    = aw_have & w_have & ~s_axi_bvalid;
    wire [3:0]    wr_addr  = aw_hs ? s_axi_awaddr : aw_addr;
    wire [31:0]   wr_data  = w_hs ? s_axi_wdata : w_data;
    wire          busy     = go | (st != L_IDLE);
    wire          wr_ctrl  = wr_do & (wr_addr == rscl_pkg::REG_CTRL);
    wire          wr_ok    = wr_ctrl | (wr_addr == rscl_pkg::REG_STATUS) |
                             (wr_addr == rscl_pkg::REG_RDATA);
    wire          b_after  = wr_do | (s_axi_bvalid & ~s_axi_bready);
    wire          ar_hs    = s_axi_arvalid & s_axi_arready;
    wire          r_after  = ar_hs | (s_axi_rvalid & ~s_axi_rready);
    wire          op_read  = cmd[rscl_pkg::CTRL_READ_BIT];
    wire [1:0]    op_idx   = cmd[rscl_pkg::CTRL_IDX_LSB +: 2];
    wire [7:0]    op_byte  = cmd[rscl_pkg::CTRL_WDATA_LSB +: 8];
    wire [31:0]   sts_word = {30'h00000000, sysclk_seen, busy};
    wire [31:0]   rd_word  =
        (s_axi_araddr == rscl_pkg::REG_CTRL)   ? {19'h00000, cmd} :
        (s_axi_araddr == rscl_pkg::REG_STATUS) ? sts_word :
        {24'h000000, rd_byte};
    wire          rd_ok    = (s_axi_araddr == rscl_pkg::REG_CTRL) |
                             (s_axi_araddr == rscl_pkg::REG_STATUS) |
                             (s_axi_araddr == rscl_pkg::REG_RDATA);

    // AXI4-Lite slave, one write and one read outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= rscl_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= rscl_pkg::RESP_OKAY;
            s_axi_rdata   <= rscl_pkg::WORD_ZERO;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= rscl_pkg::WORD_ZERO;
            cmd           <= 13'h0000;
            go            <= 1'b0;
            sysclk_seen   <= 1'b0;
        end else if (ce) begin
            sysclk_seen   <= lnk.sysclk;
            aw_got        <= aw_have & ~wr_do;
            w_got         <= w_have & ~wr_do;
            s_axi_awready <= ~(aw_have & ~wr_do) & ~b_after;
            s_axi_wready  <= ~(w_have & ~wr_do) & ~b_after;
            s_axi_bvalid  <= b_after;
            s_axi_arready <= ~r_after;
            s_axi_rvalid  <= r_after;
            if (aw_hs) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data <= s_axi_wdata;
            end
            if (wr_do) begin
                s_axi_bresp <= wr_ok ? rscl_pkg::RESP_OKAY
                                     : rscl_pkg::RESP_SLVERR;
            end
            // Commands written while busy are dropped
            if (wr_ctrl && !busy && s_axi_wstrb[0] && s_axi_wstrb[1]) begin
                cmd <= wr_data[12:0];
                go  <= 1'b1;
            end else if (st == L_IDLE) begin
                go  <= 1'b0;
            end
            if (ar_hs) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? rscl_pkg::RESP_OKAY
                                     : rscl_pkg::RESP_SLVERR;
            end
        end
    end

    // Line sequencer: index, then four pairs out or four pairs back
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st               <= L_IDLE;
            cnt              <= rscl_pkg::PAIR_ZERO;
            shreg            <= rscl_pkg::BYTE_ZERO;
            rd_byte          <= rscl_pkg::BYTE_ZERO;
            lnk.link_ctl_o   <= rscl_pkg::CTL_IDLE;
            lnk.link_ctl_oe  <= 1'b0;
            lnk.link_dat_o   <= rscl_pkg::PAIR_ZERO;
            lnk.link_dat_oe  <= 1'b0;
        end else if (ce) begin
            case (st)
                L_IDLE: begin
                    if (go) begin
                        lnk.link_ctl_o  <= op_read ? rscl_pkg::CTL_READ
                                                   : rscl_pkg::CTL_WRITE;
                        lnk.link_ctl_oe <= 1'b1;
                        lnk.link_dat_o  <= op_idx;
                        lnk.link_dat_oe <= 1'b1;
                        st              <= L_CMD;
                    end
                end
                L_CMD: begin
                    cnt <= rscl_pkg::PAIR_ZERO;
                    if (op_read) begin
                        lnk.link_ctl_oe <= 1'b0;
                        lnk.link_dat_oe <= 1'b0;
                        st              <= L_TURN;
                    end else begin
                        lnk.link_dat_o  <= op_byte[7:6];
                        shreg           <= {op_byte[5:0], 2'h0};
                        st              <= L_WDAT;
                    end
                end
                L_WDAT: begin
                    if (cnt == rscl_pkg::LAST_PAIR) begin
                        lnk.link_ctl_o  <= rscl_pkg::CTL_IDLE;
                        lnk.link_ctl_oe <= 1'b0;
                        lnk.link_dat_oe <= 1'b0;
                        st              <= L_IDLE;
                    end else begin
                        lnk.link_dat_o  <= shreg[7:6];
                        shreg           <= {shreg[5:0], 2'h0};
                        cnt             <= cnt + 2'h1;
                    end
                end
                L_TURN: begin
                    if (lnk.ctl == rscl_pkg::CTL_DATA) begin
                        shreg <= {shreg[5:0], lnk.dat};
                        cnt   <= 2'h1;
                        st    <= L_RDAT;
                    end
                end
                L_RDAT: begin
                    shreg <= {shreg[5:0], lnk.dat};
                    cnt   <= cnt + 2'h1;
                    if (cnt == rscl_pkg::LAST_PAIR) begin
                        rd_byte <= {shreg[5:0], lnk.dat};
                        st      <= L_IDLE;
                    end
                end
                default: begin
                    st <= L_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: logic/rscl_phy_end.sv
// Device end: strap capture, node and priority fields, line responder
// Summary of operation
// - Speed strap low 98.304, high 49.152
// - System supplies matching reference clock
// - Reserved select strap held at zero
// - Reset loads node straps into bits 0..5
// - Reset loads priority strap 0 into bit 0
// - Software may overwrite the node and priority fields
// - Two shared bidirectional control lines
// - Two shared bidirectional data lines
// - Reset loads priority straps 1..3
// - System clock is reference halved, sent out
`timescale 1ns/1ps
`default_nettype none
module rscl_phy_end (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       ce,
    input  wire logic       speed_select_strap,
    input  wire logic       reserved_select_strap,
    input  wire logic [5:0] node_number_strap,
    input  wire logic [3:0] priority_strap,
    output var  logic [5:0] node_number_field,
    output var  logic [3:0] priority_field,
    output var  logic       speed_mode_low,
    output var  logic       reserved_mode,
    rscl_if.phy             lnk
);
    typedef enum logic [3:0] {
        P_IDLE = 4'h1,
        P_WDAT = 4'h2,
        P_TURN = 4'h4,
        P_RDAT = 4'h8
    } rscl_pstate_e;

    rscl_pstate_e st;
    logic [1:0]   cnt;
    logic [1:0]   idx;
    logic [7:0]   shreg;
    logic         hard_load;
    logic         sysclk_q;

    wire       wr_commit = (st == P_WDAT) &&
                           (lnk.ctl == rscl_pkg::CTL_WRITE) &&
                           (cnt == rscl_pkg::LAST_PAIR);
    wire [7:0] wr_byte   = {shreg[5:0], lnk.dat};
    wire       wr_node   = wr_commit && (idx == rscl_pkg::IDX_NODE);
    wire       wr_prio   = wr_commit && (idx == rscl_pkg::IDX_PRIO);
    wire       wr_hard   = wr_commit && (idx == rscl_pkg::IDX_CMD) &&
                           wr_byte[rscl_pkg::CMD_HARD_RESET_BIT];
    wire [7:0] stat_byte = {6'h00, reserved_mode, speed_mode_low};
    wire [7:0] rd_byte   =
        (idx == rscl_pkg::IDX_NODE) ? {2'h0, node_number_field} :
        (idx == rscl_pkg::IDX_PRIO) ? {4'h0, priority_field} :
        (idx == rscl_pkg::IDX_STATUS) ? stat_byte :
        rscl_pkg::BYTE_ZERO;

    // Reference divided by two; ce only pauses it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sysclk_q <= 1'b0;
        end else if (ce) begin
            sysclk_q <= ~sysclk_q;
        end
    end
    assign lnk.sysclk = sysclk_q;

    // Speed straps only settle at hardware reset; held afterwards
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_mode_low <= speed_select_strap;
            reserved_mode  <= reserved_select_strap;
        end
    end

    // Command write is a one-cycle pulse; reload follows next edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hard_load <= 1'b0;
        end else if (ce) begin
            hard_load <= wr_hard;
        end
    end

    // Strap fields: loaded on either reset, writable after
    always_ff @(posedge aclk) begin
        if (!aresetn || (ce && hard_load)) begin
            node_number_field <= node_number_strap;
            priority_field[0] <= priority_strap[0];
            priority_field[3:1] <= priority_strap[3:1];
        end else if (ce) begin
            if (wr_node) begin
                node_number_field <= wr_byte[5:0];
            end
            if (wr_prio) begin
                priority_field <= wr_byte[3:0];
            end
        end
    end

    // Line responder: index, then four pairs in or four pairs out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st             <= P_IDLE;
            cnt            <= rscl_pkg::PAIR_ZERO;
            idx            <= rscl_pkg::IDX_NODE;
            shreg          <= rscl_pkg::BYTE_ZERO;
            lnk.phy_ctl_o  <= rscl_pkg::CTL_IDLE;
            lnk.phy_ctl_oe <= 1'b0;
            lnk.phy_dat_o  <= rscl_pkg::PAIR_ZERO;
            lnk.phy_dat_oe <= 1'b0;
        end else if (ce) begin
            case (st)
                P_IDLE: begin
                    cnt <= rscl_pkg::PAIR_ZERO;
                    if (lnk.ctl == rscl_pkg::CTL_WRITE) begin
                        idx <= lnk.dat;
                        st  <= P_WDAT;
                    end else if (lnk.ctl == rscl_pkg::CTL_READ) begin
                        idx <= lnk.dat;
                        st  <= P_TURN;
                    end
                end
                P_WDAT: begin
                    // Link dropping the write code aborts the byte
                    if (lnk.ctl != rscl_pkg::CTL_WRITE) begin
                        st <= P_IDLE;
                    end else begin
                        shreg <= wr_byte;
                        cnt   <= cnt + 2'h1;
                        if (cnt == rscl_pkg::LAST_PAIR) begin
                            st <= P_IDLE;
                        end
                    end
                end
                P_TURN: begin
                    // One quiet cycle after the link lets go
                    lnk.phy_ctl_o  <= rscl_pkg::CTL_DATA;
                    lnk.phy_ctl_oe <= 1'b1;
                    lnk.phy_dat_o  <= rd_byte[7:6];
                    lnk.phy_dat_oe <= 1'b1;
                    shreg          <= {rd_byte[5:0], 2'h0};
                    cnt            <= rscl_pkg::PAIR_ZERO;
                    st             <= P_RDAT;
                end
                P_RDAT: begin
                    if (cnt == rscl_pkg::LAST_PAIR) begin
                        lnk.phy_ctl_o  <= rscl_pkg::CTL_IDLE;
                        lnk.phy_ctl_oe <= 1'b0;
                        lnk.phy_dat_oe <= 1'b0;
                        st             <= P_IDLE;
                    end else begin
                        lnk.phy_dat_o <= shreg[7:6];
                        shreg         <= {shreg[5:0], 2'h0};
                        cnt           <= cnt + 2'h1;
                    end
                end
                default: begin
                    st <= P_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: pkg/rscl_if.sv
// Shared control and data lines between device and link controller
`timescale 1ns/1ps
`default_nettype none
interface rscl_if;
    logic [1:0] phy_ctl_o;
    logic       phy_ctl_oe;
    logic [1:0] phy_dat_o;
    logic       phy_dat_oe;
    logic [1:0] link_ctl_o;
    logic       link_ctl_oe;
    logic [1:0] link_dat_o;
    logic       link_dat_oe;
    logic       sysclk;
    logic [1:0] ctl;
    logic [1:0] dat;

    // Undriven lines read low, as with board pull-downs
    assign ctl = phy_ctl_oe ? phy_ctl_o :
                 (link_ctl_oe ? link_ctl_o : 2'h0);
    assign dat = phy_dat_oe ? phy_dat_o :
                 (link_dat_oe ? link_dat_o : 2'h0);

    modport phy (
        input  ctl,
        input  dat,
        output phy_ctl_o,
        output phy_ctl_oe,
        output phy_dat_o,
        output phy_dat_oe,
        output sysclk
    );

    modport link (
        input  ctl,
        input  dat,
        input  sysclk,
        output link_ctl_o,
        output link_ctl_oe,
        output link_dat_o,
        output link_dat_oe
    );
endinterface
`default_nettype wire

// file: pkg/rscl_pkg.sv
// Shared constants for the strap configuration loader and its link partner
package rscl_pkg;
    // Two-bit code carried on the control lines
    localparam logic [1:0] CTL_IDLE  = 2'h0;
    localparam logic [1:0] CTL_WRITE = 2'h1;
    localparam logic [1:0] CTL_READ  = 2'h2;
    localparam logic [1:0] CTL_DATA  = 2'h3;

    // Device register indices carried on the data lines
    localparam logic [1:0] IDX_NODE   = 2'h0;
    localparam logic [1:0] IDX_PRIO   = 2'h1;
    localparam logic [1:0] IDX_CMD    = 2'h2;
    localparam logic [1:0] IDX_STATUS = 2'h3;

    // Field positions inside device registers
    localparam int CMD_HARD_RESET_BIT = 0;
    localparam int STAT_SPEED_BIT     = 0;
    localparam int STAT_RESV_BIT      = 1;

    // Data pairs per byte, last pair count
    localparam logic [1:0] LAST_PAIR = 2'h3;

    // Controller register byte addresses (AXI4-Lite)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RDATA  = 4'h8;

    // Controller command word layout
    localparam int CTRL_WDATA_LSB = 0;
    localparam int CTRL_IDX_LSB   = 8;
    localparam int CTRL_READ_BIT  = 12;

    // Controller status word layout
    localparam int STS_BUSY_BIT   = 0;
    localparam int STS_SYSCLK_BIT = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Reset values
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;
    localparam logic [1:0]  PAIR_ZERO = 2'h0;
endpackage

// file: test/rscl_lines_checker.sv
// Assertions on the shared lines between the device and link ends
`timescale 1ns/1ps
`default_nettype none
module rscl_lines_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       ce,
    input wire logic [1:0] phy_ctl_o,
    input wire logic       phy_ctl_oe,
    input wire logic       phy_dat_oe,
    input wire logic [1:0] link_ctl_o,
    input wire logic       link_ctl_oe,
    input wire logic       link_dat_oe,
    input wire logic       sysclk,
    input wire logic [1:0] ctl
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_sysclk_half: assert property (
        $past(aresetn) && $past(ce) |-> sysclk != $past(sysclk))
        else $error("sysclk did not toggle");
    chk_reset_quiet: assert property (
        $rose(aresetn) |-> !phy_ctl_oe && !phy_dat_oe && !link_ctl_oe
        && !link_dat_oe && !sysclk)
        else $error("lines driven or sysclk high out of reset");
    chk_no_contention: assert property (
        !(phy_ctl_oe && link_ctl_oe) && !(phy_dat_oe && link_dat_oe))
        else $error("both ends drive a shared line");
    chk_write_frame: assert property (
        link_ctl_oe && link_ctl_o == rscl_pkg::CTL_WRITE
        && !$past(link_ctl_oe) |-> (link_ctl_oe && link_dat_oe
        && link_ctl_o == rscl_pkg::CTL_WRITE)[*5] ##1 !link_ctl_oe)
        else $error("write frame not five cycles");
    chk_read_turn: assert property (
        link_ctl_oe && link_ctl_o == rscl_pkg::CTL_READ
        && !$past(link_ctl_oe) |=> !link_ctl_oe && !phy_ctl_oe
        && !link_dat_oe && !phy_dat_oe ##1 (phy_ctl_oe && phy_dat_oe
        && phy_ctl_o == rscl_pkg::CTL_DATA)[*4] ##1 !phy_ctl_oe)
        else $error("read turnaround or answer length wrong");
    chk_phy_answers: assert property (
        $rose(phy_ctl_oe) |-> $past(ctl, 2) == rscl_pkg::CTL_READ)
        else $error("device drove without a read request");
    chk_link_codes: assert property (
        $rose(link_ctl_oe) |-> link_ctl_o == rscl_pkg::CTL_WRITE
        || link_ctl_o == rscl_pkg::CTL_READ)
        else $error("link opened with an unknown code");
    chk_phy_data_code: assert property (
        phy_ctl_oe |-> phy_ctl_o == rscl_pkg::CTL_DATA && phy_dat_oe)
        else $error("device drives control without data");
endmodule
`default_nettype wire

// file: test/testbench.sv
// Bench joining device and link ends, driven over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        aclk, aresetn, ce, speed_strap, resv_strap;
    logic [5:0]  node_strap, node_field;
    logic [3:0]  prio_strap, prio_field, awaddr, araddr, wstrb;
    logic        speed_low, resv_mode, awvalid, awready, wvalid, wready;
    logic        bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  wire_sr, rd_sr;
    logic        sclk_prev;
    int          n_fail, tests_run;

    rscl_if link_bus ();
    rscl_phy_end rscl_phy_end_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .speed_select_strap(speed_strap),
        .reserved_select_strap(resv_strap),
        .node_number_strap(node_strap), .priority_strap(prio_strap),
        .node_number_field(node_field), .priority_field(prio_field),
        .speed_mode_low(speed_low), .reserved_mode(resv_mode),
        .lnk(link_bus));
    rscl_link_end rscl_link_end_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lnk(link_bus));
    rscl_lines_checker rscl_lines_checker_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .phy_ctl_o(link_bus.phy_ctl_o), .phy_ctl_oe(link_bus.phy_ctl_oe),
        .phy_dat_oe(link_bus.phy_dat_oe),
        .link_ctl_o(link_bus.link_ctl_o),
        .link_ctl_oe(link_bus.link_ctl_oe),
        .link_dat_oe(link_bus.link_dat_oe),
        .sysclk(link_bus.sysclk), .ctl(link_bus.ctl));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Pairs seen on the wire, oldest pair ends up in the top bits
    always @(posedge aclk) begin
        if (link_bus.link_ctl_oe && link_bus.ctl === rscl_pkg::CTL_WRITE) begin
            wire_sr <= {wire_sr[5:0], link_bus.dat};
        end
        if (link_bus.phy_ctl_oe) begin
            rd_sr <= {rd_sr[5:0], link_bus.dat};
        end
    end

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic hang();
        n_fail++;
        finish_test();
    endtask

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) hang();
    endtask

    task automatic axi_read(input logic [3:0] a);
        bit done;
        done = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) hang();
    endtask

    // Poll busy; a stuck controller ends the run
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            axi_read(rscl_pkg::REG_STATUS);
            if (v[rscl_pkg::STS_BUSY_BIT] === 1'b0) return;
        end
        hang();
    endtask

    function automatic logic [31:0] cmd(input logic [1:0] idx,
                                        input logic [7:0] b, input logic rd);
        return {19'h0, rd, 2'h0, idx, b};
    endfunction

    task automatic link_cmd(input logic [1:0] idx, input logic [7:0] b,
                            input logic rd);
        axi_write(rscl_pkg::REG_CTRL, cmd(idx, b, rd));
        check("ctrl bresp", {30'h0, r}, 32'h0);
        wait_idle();
        if (rd) axi_read(rscl_pkg::REG_RDATA);
    endtask

    task automatic hw_reset(input logic sp, input logic [5:0] nd,
                            input logic [3:0] pr);
        @(posedge aclk);
        aresetn <= 1'b0;
        speed_strap <= sp;
        node_strap <= nd;
        prio_strap <= pr;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {speed_strap, resv_strap, node_strap, prio_strap} = '0;
        ce = 1'b1;
        wstrb = 4'hF;
        hw_reset(1'b1, 6'h2A, 4'h5);
        check("node", node_field, 6'h2A);
        check("prio", prio_field, 4'h5);
        check("speed", speed_low, 1'b1);
        check("resv", resv_mode, 1'b0);
        // Straps move after release; fields must not follow
        node_strap <= 6'h13;
        prio_strap <= 4'hC;
        speed_strap <= 1'b0;
        repeat (3) @(posedge aclk);
        check("node held", node_field, 6'h2A);
        check("prio held", prio_field, 4'h5);
        check("speed held", speed_low, 1'b1);
        link_cmd(rscl_pkg::IDX_NODE, 8'h15, 1'b0);
        check("wire pairs", wire_sr, 8'h15);
        check("node sw", node_field, 6'h15);
        link_cmd(rscl_pkg::IDX_PRIO, 8'h0A, 1'b0);
        check("prio sw", prio_field, 4'hA);
        link_cmd(rscl_pkg::IDX_NODE, 8'h00, 1'b1);
        check("rdata node", v[7:0], 8'h15);
        check("read pairs", rd_sr, 8'h15);
        link_cmd(rscl_pkg::IDX_STATUS, 8'h00, 1'b1);
        check("rdata status", v[7:0], 8'h01);
        // Status reads land three edges apart, an odd count of toggles
        axi_read(rscl_pkg::REG_STATUS);
        sclk_prev = v[rscl_pkg::STS_SYSCLK_BIT];
        axi_read(rscl_pkg::REG_STATUS);
        check("sysclk bit", v[rscl_pkg::STS_SYSCLK_BIT], !sclk_prev);
        // Second order while busy is dropped
        axi_write(rscl_pkg::REG_CTRL, cmd(rscl_pkg::IDX_NODE, 8'h3F, 1'b0));
        axi_write(rscl_pkg::REG_CTRL, cmd(rscl_pkg::IDX_NODE, 8'h21, 1'b0));
        wait_idle();
        check("node busy drop", node_field, 6'h3F);
        link_cmd(rscl_pkg::IDX_CMD, 8'h01, 1'b0);
        check("node swrst", node_field, 6'h13);
        check("prio swrst", prio_field, 4'hC);
        check("speed swrst", speed_low, 1'b1);
        axi_read(4'hC);
        check("unmapped", {30'h0, r}, {30'h0, rscl_pkg::RESP_SLVERR});
        axi_read(rscl_pkg::REG_CTRL);
        check("ctrl rresp", {30'h0, r}, 32'h0);
        check("ctrl read", v, cmd(rscl_pkg::IDX_CMD, 8'h01, 1'b0));
        // Write without the low byte lanes must not start a transfer
        wstrb <= 4'h0;
        link_cmd(rscl_pkg::IDX_NODE, 8'h01, 1'b0);
        check("wstrb drop", node_field, 6'h13);
        wstrb <= 4'hF;
        // Enable low freezes the divided clock; odd gap catches a toggle
        ce <= 1'b0;
        repeat (2) @(posedge aclk);
        sclk_prev = link_bus.sysclk;
        repeat (3) @(posedge aclk);
        check("ce freeze", link_bus.sysclk, sclk_prev);
        ce <= 1'b1;
        hw_reset(1'b0, 6'h3F, 4'h8);
        check("speed fast", speed_low, 1'b0);
        check("node rst2", node_field, 6'h3F);
        check("prio rst2", prio_field, 4'h8);
        finish_test();
    end
endmodule
`default_nettype wire
